//--- src/bpe_core.sv
// Purpose: Pattern generator, checker, flags and masks with Wishbone access
// Assumes: Bit strobes are one-cycle pulses synchronous to i_sys_clk
// Notes:   Checker is self-synchronising from its own receive history
//
// Summary of operation
// - Invert outgoing bits when invert control set
// - Load strobe rising edge reloads generator
// - Repeat length is field value plus 17
// - Length ignored for pseudorandom receive patterns
// - Single-error strobe rising edge flips one bit
// - Error rate field inserts decade-ratio errors
// - Sync flag after 32 matches, both edges
// - Loss flag latches on search, held until read
// - All-zeros flag after 32 zeros, clears after one
// - All-ones flag after 32 ones, clears after zero
// - Error counter overflow flag, cleared on read
// - Bit counter overflow flag, cleared on read
// - Bit error flag only while synced, read clears
// - Condition masks gate both-edge interrupts
// - Event masks gate event interrupts
// - Alternating words repeat for word count
// - Bit counter counts while synced, saturates
// - Force_a rising edge restarts pattern search
`timescale 1ns/1ps
module bpe_core (
  // Clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_reset,
  // Wishbone slave
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [9:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic      [31:0] o_wb_dat,
  output logic             o_wb_ack,
  // Transmit stream
  input  wire logic        i_tx_bit_en,
  output logic             o_tx_bit,
  // Receive stream
  input  wire logic        i_rx_bit_en,
  input  wire logic        i_rx_bit,
  // Status outputs
  output logic             o_synced,
  output logic             o_irq
);
  typedef struct packed {
    logic [7:0]                  ctrl1;
    logic [7:0]                  ctrl2;
    logic [7:0]                  awc;
    logic [6:0]                  mask;
    logic [31:0]                 pat;
    logic [6:0]                  status;
    logic [6:0]                  pend;
    logic                        ack;
    logic [31:0]                 rdat;
    logic [31:0]                 gen;
    logic [4:0]                  gidx;
    logic [7:0]                  wcnt;
    logic                        wsel;
    logic                        sbe_pend;
    logic                        tx_bit;
    logic [31:0]                 hist;
    logic                        synced;
    logic [5:0]                  match;
    logic [5:0]                  win;
    logic [5:0]                  werr;
    logic [5:0]                  zrun;
    logic [5:0]                  orun;
    logic [bpe_pkg::BCNT_W-1:0]  bcnt;
    logic [bpe_pkg::ECNT_W-1:0]  ecnt;
    logic [3:0]                  cond_q;
  } bpe_core_s;

  bpe_core_s   st_q;
  bpe_core_s   st_d;
  bpe_err_if   err_link ();

  logic [7:0]  idx;
  logic        acc;
  logic        wr;
  logic        rd_status;
  logic [2:0]  ps;
  logic [5:0]  rep_len;
  logic [9:0]  taps;
  logic        gen_bit;
  logic        exp_bit;
  logic        rx_d;
  logic [3:0]  cond;
  logic [6:0]  evt;
  logic [6:0]  rise;
  logic [6:0]  clr_ok;
  logic [7:0]  c1_new;
  logic [7:0]  c2_new;
  logic [31:0] rd_word;

  assign idx       = i_wb_adr[9:2];
  assign acc       = i_wb_cyc && i_wb_stb && !st_q.ack;
  assign wr        = acc && i_wb_we && i_wb_sel[0];
  assign rd_status = acc && !i_wb_we && (idx == bpe_pkg::IDX_STATUS);
  assign ps        = st_q.ctrl1[bpe_pkg::C1_PS_LO +: 3];
  assign rep_len   = bpe_pkg::REP_LEN_BASE + {2'b00, st_q.ctrl2[bpe_pkg::C2_RPL_LO +: 4]};

  // Feedback taps, upper five bits and lower five bits, as stage numbers
  always_comb begin
    case (ps)
      bpe_pkg::PS_P7:   taps = {5'd7, 5'd6};
      bpe_pkg::PS_P9:   taps = {5'd9, 5'd5};
      bpe_pkg::PS_P11:  taps = {5'd11, 5'd9};
      bpe_pkg::PS_P15:  taps = {5'd15, 5'd14};
      bpe_pkg::PS_QRSS: taps = {5'd20, 5'd17};
      default:          taps = {5'd7, 5'd6};
    endcase
  end

  // Generator bit for the current mode
  always_comb begin
    case (ps)
      bpe_pkg::PS_REP, bpe_pkg::PS_DALY: gen_bit = st_q.gen[st_q.gidx];
      bpe_pkg::PS_ALT: gen_bit = st_q.wsel ? st_q.gen[5'h10 + st_q.gidx] : st_q.gen[st_q.gidx];
      default:         gen_bit = st_q.gen[taps[9:5] - 5'd1] ^ st_q.gen[taps[4:0] - 5'd1];
    endcase
  end

  // Expected receive bit from history; length field unused for pseudorandom
  assign rx_d = i_rx_bit ^ st_q.ctrl1[bpe_pkg::C1_RINV];
  always_comb begin
    case (ps)
      bpe_pkg::PS_REP, bpe_pkg::PS_DALY: exp_bit = st_q.hist[rep_len[4:0] - 5'd1];
      bpe_pkg::PS_ALT: exp_bit = st_q.hist[bpe_pkg::WORD_BITS - 5'd1];
      default:         exp_bit = st_q.hist[taps[9:5] - 5'd1] ^ st_q.hist[taps[4:0] - 5'd1];
    endcase
  end

  assign err_link.bit_en = i_tx_bit_en;
  assign err_link.rate   = st_q.ctrl2[bpe_pkg::C2_EIB_LO +: 3];

  bpe_rate_timer u_rate (
    .i_sys_clk (i_sys_clk),
    .i_reset   (i_reset),
    .err       (err_link)
  );

  assign c1_new = (wr && idx == bpe_pkg::IDX_CTRL1) ? i_wb_dat[7:0] : st_q.ctrl1;
  assign c2_new = (wr && idx == bpe_pkg::IDX_CTRL2) ? i_wb_dat[7:0] : st_q.ctrl2;

  // Read mux; unmapped indexes read as zero
  always_comb begin
    rd_word = '0;
    case (idx)
      bpe_pkg::IDX_STATUS: rd_word[6:0] = st_q.status;
      bpe_pkg::IDX_MASK:   rd_word[6:0] = st_q.mask;
      bpe_pkg::IDX_AWC:    rd_word[7:0] = st_q.awc;
      bpe_pkg::IDX_CTRL1:  rd_word[7:0] = st_q.ctrl1;
      bpe_pkg::IDX_CTRL2:  rd_word[7:0] = st_q.ctrl2;
      default: begin
        if (idx >= bpe_pkg::IDX_PAT0 && idx <= bpe_pkg::IDX_PAT3) begin
          rd_word[7:0] = st_q.pat[8 * (idx[1:0]) +: 8];
        end else if (idx >= bpe_pkg::IDX_BCNT0 && idx <= bpe_pkg::IDX_BCNT3) begin
          rd_word[7:0] = st_q.bcnt[8 * (2'(idx - bpe_pkg::IDX_BCNT0)) +: 8];
        end
      end
    endcase
  end

  always_comb begin
    st_d = st_q;
    evt  = '0;
    st_d.ack = acc;
    if (acc) begin
      st_d.rdat = i_wb_we ? 32'h00000000 : rd_word;
    end
    if (wr) begin
      case (idx)
        bpe_pkg::IDX_MASK: st_d.mask = i_wb_dat[6:0];
        bpe_pkg::IDX_AWC:  st_d.awc  = i_wb_dat[7:0];
        default: begin
          if (idx >= bpe_pkg::IDX_PAT0 && idx <= bpe_pkg::IDX_PAT3) begin
            st_d.pat[8 * (idx[1:0]) +: 8] = i_wb_dat[7:0];
          end
        end
      endcase
    end
    st_d.ctrl1 = c1_new;
    st_d.ctrl2 = c2_new;

    // Transmit side
    if (!st_q.ctrl1[bpe_pkg::C1_LOAD] && c1_new[bpe_pkg::C1_LOAD]) begin
      st_d.gen  = st_q.pat;
      st_d.gidx = '0;
      st_d.wcnt = '0;
      st_d.wsel = 1'b0;
    end else if (i_tx_bit_en) begin
      st_d.tx_bit = gen_bit ^ st_q.ctrl1[bpe_pkg::C1_TX_INVERT]
                    ^ (st_q.sbe_pend | err_link.hit);
      st_d.sbe_pend = 1'b0;
      case (ps)
        bpe_pkg::PS_REP, bpe_pkg::PS_DALY: begin
          st_d.gidx = (6'(st_q.gidx) + 6'd1 >= rep_len) ? 5'd0 : st_q.gidx + 5'd1;
        end
        bpe_pkg::PS_ALT: begin
          st_d.gidx = st_q.gidx + 5'd1;
          if (st_q.gidx == bpe_pkg::WORD_BITS - 5'd1) begin
            st_d.gidx = '0;
            st_d.wcnt = st_q.wcnt + 8'h01;
            if (st_q.wcnt == st_q.awc - 8'h01) begin
              st_d.wcnt = '0;
              st_d.wsel = !st_q.wsel;
            end
          end
        end
        default: st_d.gen = {st_q.gen[30:0], gen_bit};
      endcase
    end
    // Set after the strobe's clear, so a strobe in the same cycle cannot eat it
    if (!st_q.ctrl2[bpe_pkg::C2_SBE] && c2_new[bpe_pkg::C2_SBE]) begin
      st_d.sbe_pend = 1'b1;
    end

    // Receive side
    if (i_rx_bit_en) begin
      st_d.hist = {st_q.hist[30:0], rx_d};
      st_d.zrun = rx_d ? 6'd0 : ((st_q.zrun == bpe_pkg::RUN_LEN) ? st_q.zrun : st_q.zrun + 6'd1);
      st_d.orun = !rx_d ? 6'd0 : ((st_q.orun == bpe_pkg::RUN_LEN) ? st_q.orun : st_q.orun + 6'd1);
      if (!st_q.synced) begin
        st_d.match = (rx_d != exp_bit) ? 6'd0 : st_q.match + 6'd1;
        if (rx_d == exp_bit && st_q.match == bpe_pkg::SYNC_MATCH - 6'd1) begin
          st_d.synced = 1'b1;
          st_d.win    = '0;
          st_d.werr   = '0;
        end
      end else begin
        if (st_q.bcnt != '1) begin
          st_d.bcnt = st_q.bcnt + 32'h00000001;
          evt[bpe_pkg::ST_BCOV] = (st_q.bcnt == 32'hfffffffe);
        end
        st_d.win = (st_q.win == bpe_pkg::LOS_WINDOW - 6'd1) ? 6'd0 : st_q.win + 6'd1;
        if (st_q.win == bpe_pkg::LOS_WINDOW - 6'd1) begin
          st_d.werr = '0;
        end
        if (rx_d != exp_bit) begin
          evt[bpe_pkg::ST_BERR] = 1'b1;
          if (st_q.ecnt != '1) begin
            st_d.ecnt = st_q.ecnt + 24'h000001;
            evt[bpe_pkg::ST_ECOV] = (st_q.ecnt == 24'hfffffe);
          end
          st_d.werr = st_q.werr + 6'd1;
          if (st_q.werr == bpe_pkg::LOS_ERRS - 6'd1) begin
            st_d.synced = 1'b0; // Too many errors: search again
            st_d.match  = '0;
          end
        end
      end
    end
    if (!st_q.ctrl1[bpe_pkg::C1_FORCE_A] && c1_new[bpe_pkg::C1_FORCE_A]) begin
      st_d.synced = 1'b0;
      st_d.match  = '0;
    end
    if (!st_q.ctrl1[bpe_pkg::C1_LC] && c1_new[bpe_pkg::C1_LC]) begin
      st_d.bcnt = '0;
      st_d.ecnt = '0;
    end

    // Flags: clear on status read first, then set so a new event wins
    st_d.cond_q = cond;
    if (rd_status) begin
      st_d.status = st_q.status & ~clr_ok;
      st_d.pend   = '0;
    end
    st_d.status = st_d.status | rise;
    st_d.pend   = st_d.pend | {evt[6:4], cond ^ st_q.cond_q};
  end

  // Conditions: synced, searching, all zeros, all ones
  assign cond = {st_q.orun == bpe_pkg::RUN_LEN, st_q.zrun == bpe_pkg::RUN_LEN,
                 !st_q.synced, st_q.synced};
  assign rise = {evt[6:4], cond & ~st_q.cond_q};
  // Loss flag holds until read even after force_a; event flags and the loss flag clear on any read, other condition flags only when cause gone
  assign clr_ok = {3'b111, !cond[3], !cond[2], 1'b1, !cond[0]};

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      st_q        <= '0;
      st_q.status <= bpe_pkg::STATUS_RST;
      st_q.cond_q <= 4'b0010;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_wb_ack = st_q.ack;
  assign o_wb_dat = st_q.rdat;
  assign o_tx_bit = st_q.tx_bit;
  assign o_synced = st_q.synced;
  assign o_irq    = |(st_q.pend & st_q.mask);
endmodule

//--- src/bpe_pkg.sv
// Purpose: Shared constants for the pattern/error control block
// Assumes: Register index times four gives the Wishbone byte address
// Notes:   Indexes are 8-bit, data registers are 8-bit in the low lane
package bpe_pkg;
  // Register indexes
  localparam logic [7:0] IDX_STATUS = 8'h26;
  localparam logic [7:0] IDX_MASK   = 8'h27;
  localparam logic [7:0] IDX_AWC    = 8'hdb;
  localparam logic [7:0] IDX_PAT0   = 8'hdc;
  localparam logic [7:0] IDX_PAT3   = 8'hdf;
  localparam logic [7:0] IDX_CTRL1  = 8'he0;
  localparam logic [7:0] IDX_CTRL2  = 8'he1;
  localparam logic [7:0] IDX_BCNT0  = 8'he3;
  localparam logic [7:0] IDX_BCNT3  = 8'he6;
  localparam logic [7:0] RST_BYTE   = 8'h00;
  // Control 1 fields
  localparam int C1_FORCE_A = 0;
  localparam int C1_LC     = 1;
  localparam int C1_PS_LO  = 2;
  localparam int C1_RINV   = 5;
  localparam int C1_TX_INVERT   = 6;
  localparam int C1_LOAD   = 7;
  // Control 2 fields
  localparam int C2_RPL_LO = 0;
  localparam int C2_SBE    = 4;
  localparam int C2_EIB_LO = 5;
  // Status and mask bit positions
  localparam int ST_SYNC  = 0;
  localparam int ST_LOST  = 1;
  localparam int ST_ZERO  = 2;
  localparam int ST_ONES  = 3;
  localparam int ST_ECOV  = 4;
  localparam int ST_BCOV  = 5;
  localparam int ST_BERR  = 6;
  localparam logic [6:0] STATUS_RST = 7'h00;
  // Pattern select codes
  localparam logic [2:0] PS_P7   = 3'h0;
  localparam logic [2:0] PS_P11  = 3'h1;
  localparam logic [2:0] PS_P15  = 3'h2;
  localparam logic [2:0] PS_QRSS = 3'h3;
  localparam logic [2:0] PS_REP  = 3'h4;
  localparam logic [2:0] PS_ALT  = 3'h5;
  localparam logic [2:0] PS_DALY = 3'h6;
  localparam logic [2:0] PS_P9   = 3'h7;
  // Counts
  localparam logic [5:0] REP_LEN_BASE = 6'h11;
  localparam logic [5:0] SYNC_MATCH   = 6'h20;
  localparam logic [5:0] RUN_LEN      = 6'h20;
  localparam logic [5:0] LOS_WINDOW   = 6'h20;
  localparam logic [5:0] LOS_ERRS     = 6'h04;
  localparam logic [4:0] WORD_BITS    = 5'h10;
  localparam int BCNT_W = 32;
  localparam int ECNT_W = 24;
  localparam int RATE_W = 24;
endpackage

//--- src/bpe_err_if.sv
// Purpose: Link between the generator and the automatic error-rate timer
// Assumes: One clock domain
// Notes:   hit is combinational, valid with bit_en
`timescale 1ns/1ps
interface bpe_err_if;
  logic       bit_en;
  logic [2:0] rate;
  logic       hit;
  modport gen (output bit_en, output rate, input hit);
  modport timer (input bit_en, input rate, output hit);
endinterface

//--- src/bpe_rate_timer.sv
// Purpose: Counts generated bits and flags one per decade ratio
// Assumes: rate 0 disables, rate n gives one hit per ten to the n bits
// Notes:   Counter restarts whenever the rate code changes
`timescale 1ns/1ps
module bpe_rate_timer (
  // Clock and reset
  input  wire logic i_sys_clk,
  input  wire logic i_reset,
  // Generator side
  bpe_err_if.timer  err
);
  typedef struct packed {
    logic [bpe_pkg::RATE_W-1:0] cnt;
    logic [2:0]                 rate;
  } bpe_timer_s;

  bpe_timer_s                 st_q;
  bpe_timer_s                 st_d;
  logic [bpe_pkg::RATE_W-1:0] limit;

  always_comb begin
    case (err.rate)
      3'h1:    limit = 24'h000009;
      3'h2:    limit = 24'h000063;
      3'h3:    limit = 24'h0003e7;
      3'h4:    limit = 24'h00270f;
      3'h5:    limit = 24'h01869f;
      3'h6:    limit = 24'h0f423f;
      3'h7:    limit = 24'h98967f;
      default: limit = 24'h000000;
    endcase
  end

  assign err.hit = (err.rate != 3'h0) && err.bit_en && (st_q.cnt == limit);

  always_comb begin
    st_d = st_q;
    st_d.rate = err.rate;
    if (err.rate != st_q.rate) begin
      st_d.cnt = '0;
    end else if (err.bit_en && err.rate != 3'h0) begin
      st_d.cnt = (st_q.cnt == limit) ? '0 : st_q.cnt + 24'h000001;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
endmodule

//--- tb/bpe_monitor.sv
// Purpose: Port-level checks of the pattern/error core
// Assumes: One clock, synchronous active-high reset
// Notes:   Sync check is only a lower bound on received bits
`timescale 1ns/1ps
module bpe_monitor (
  // Clock and reset
  input wire logic        i_sys_clk,
  input wire logic        i_reset,
  // Bus
  input wire logic        i_wb_cyc,
  input wire logic        i_wb_stb,
  input wire logic        i_wb_we,
  input wire logic [9:0]  i_wb_adr,
  input wire logic [31:0] o_wb_dat,
  input wire logic        o_wb_ack,
  // Streams
  input wire logic        i_tx_bit_en,
  input wire logic        o_tx_bit,
  input wire logic        i_rx_bit_en,
  input wire logic        o_synced,
  input wire logic        o_irq
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  logic [5:0] rx_n_q;
  logic       take;
  logic       rd_st;
  assign take  = i_wb_cyc && i_wb_stb && !o_wb_ack;
  assign rd_st = take && !i_wb_we && i_wb_adr[9:2] == bpe_pkg::IDX_STATUS;
  // Saturating, so a long run never wraps below the threshold
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) rx_n_q <= 6'h00;
    else if (i_rx_bit_en && rx_n_q != 6'h3f) rx_n_q <= rx_n_q + 6'h01;
  end
  chk_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack held past one cycle");
  chk_ack_taken: assert property (take |=> o_wb_ack)
    else $error("request not answered next cycle");
  chk_ack_unasked: assert property (!(i_wb_cyc && i_wb_stb) |=> !o_wb_ack)
    else $error("ack without request");
  chk_dat_upper: assert property (o_wb_ack |-> o_wb_dat[31:8] == 24'h000000)
    else $error("read data upper bits set");
  chk_tx_hold: assert property (!i_tx_bit_en && !i_wb_cyc |=> $stable(o_tx_bit))
    else $error("tx bit moved without strobe");
  chk_irq_read: assert property (rd_st && !i_rx_bit_en && !$past(i_rx_bit_en)
    && !$past(i_rx_bit_en, 2) |=> !o_irq) else $error("irq kept after status read");
  chk_sync_rx: assert property ($rose(o_synced) |-> $past(i_rx_bit_en))
    else $error("sync rose without a received bit");
  chk_sync_count: assert property ($rose(o_synced) |-> rx_n_q >= 6'h20)
    else $error("sync before 32 received bits");
endmodule

bind bpe_core bpe_monitor bpe_monitor_i (
  .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_wb_cyc(i_wb_cyc),
  .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
  .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_tx_bit_en(i_tx_bit_en),
  .o_tx_bit(o_tx_bit), .i_rx_bit_en(i_rx_bit_en), .o_synced(o_synced),
  .o_irq(o_irq)
);

//--- tb/bpe_line_model.sv
// Purpose: Framer time-slot model giving transmit and receive strobes
// Assumes: Mode 0 idle, 1 loop back, 2 all zeros, 3 all ones
// Notes:   Between strobes the receive bit toggles, so stale data never looks valid
`timescale 1ns/1ps
module bpe_line_model (
  // Clock and reset
  input  wire logic       i_sys_clk,
  input  wire logic       i_reset,
  // Bench control
  input  wire logic [1:0] i_mode,
  input  wire logic [1:0] i_gap,
  // Core side
  input  wire logic       i_tx_bit,
  output logic            o_tx_bit_en,
  output logic            o_rx_bit_en,
  output logic            o_rx_bit
);
  logic [1:0] cnt_q;
  always @(posedge i_sys_clk) begin
    if (i_reset || i_mode == 2'h0) begin
      cnt_q       <= 2'h0;
      o_tx_bit_en <= 1'b0;
      o_rx_bit_en <= 1'b0;
      o_rx_bit    <= i_reset ? 1'b0 : ~o_rx_bit;
    end else begin
      cnt_q       <= (cnt_q == i_gap) ? 2'h0 : cnt_q + 2'h1;
      o_tx_bit_en <= cnt_q == 2'h0;
      o_rx_bit_en <= cnt_q == 2'h0;
      if (cnt_q == 2'h0) o_rx_bit <= (i_mode == 2'h1) ? i_tx_bit : i_mode[0];
      else o_rx_bit <= ~o_rx_bit;
    end
  end
endmodule

//--- tb/tb.sv
// Purpose: Register and stream tests of the pattern/error core
// Assumes: Line model makes all strobes; bench is the Wishbone master
// Notes:   Overflows of the wide counters are out of reach in a short run
`timescale 1ns/1ps
module tb;
  logic         clk  = 1'b0;
  logic         rst  = 1'b1;
  logic         cyc  = 1'b0;
  logic         stb  = 1'b0;
  logic         we   = 1'b0;
  logic [9:0]   adr  = 10'h000;
  logic [31:0]  wdat = 32'h00000000;
  logic [1:0]   mode = 2'h0;
  logic [1:0]   gap  = 2'h0;
  logic [31:0]  rdat;
  logic         ack, tx_b, tx_en, rx_en, rx_b, synced, irq;
  logic [7:0]   q;
  logic [255:0] v, e;
  logic [7:0]   regs [4] = '{bpe_pkg::IDX_STATUS, bpe_pkg::IDX_MASK, bpe_pkg::IDX_AWC,
                             bpe_pkg::IDX_CTRL2};
  logic [2:0]   prbs [5] = '{bpe_pkg::PS_P7, bpe_pkg::PS_P9, bpe_pkg::PS_P11,
                             bpe_pkg::PS_P15, bpe_pkg::PS_QRSS};
  int           failures = 0;
  int           n_tests  = 0;
  localparam logic [31:0] PAT = 32'h9c35a6e1;
  initial begin
    forever #12.5 clk = ~clk;
  end
  bpe_core bpe_core_i (.i_sys_clk(clk), .i_reset(rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'h1), .i_wb_dat(wdat), .o_wb_dat(rdat),
    .o_wb_ack(ack), .i_tx_bit_en(tx_en), .o_tx_bit(tx_b), .i_rx_bit_en(rx_en),
    .i_rx_bit(rx_b), .o_synced(synced), .o_irq(irq));
  bpe_line_model bpe_line_model_i (.i_sys_clk(clk), .i_reset(rst), .i_mode(mode),
    .i_gap(gap), .i_tx_bit(tx_b), .o_tx_bit_en(tx_en), .o_rx_bit_en(rx_en), .o_rx_bit(rx_b));
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [255:0] seen, input logic [255:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Held until ack; a slow answer only costs time, up to the bound
  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= {24'h000000, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) begin
      failures++;
      summarize();
    end
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  // Collects n transmitted bits, each read the cycle after its strobe
  task automatic grab(input int n);
    int k;
    int t;
    logic p;
    k = 0;
    t = 0;
    p = 1'b0;
    v = '0;
    while (k < n && t < 5000) begin
      @(negedge clk);
      t++;
      if (p) begin
        v[k] = tx_b;
        k++;
      end
      p = tx_en;
    end
    if (k < n) begin
      failures++;
      summarize();
    end
    @(posedge clk);
  endtask
  task automatic cfg(input logic [2:0] ps, input logic inv, input logic [3:0] len,
                     input logic [2:0] rate, input logic [31:0] p);
    mode <= 2'h0;
    for (int i = 0; i < 4; i++) wb(1'b1, bpe_pkg::IDX_PAT0 + 8'(i), p[8*i +: 8]);
    wb(1'b1, bpe_pkg::IDX_CTRL2, {rate, 1'b0, len});
    wb(1'b1, bpe_pkg::IDX_CTRL1, {1'b0, inv, inv, ps, 2'b00});
    wb(1'b1, bpe_pkg::IDX_CTRL1, {1'b1, inv, inv, ps, 2'b00});
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      wb(1'b0, regs[i], 8'h00);
      chk(q, 8'h00);
    end
    wb(1'b1, bpe_pkg::IDX_MASK, 8'hff);
    wb(1'b0, bpe_pkg::IDX_MASK, 8'h00);
    chk(q, 8'h7f);
    wb(1'b1, 8'h10, 8'hff);
    wb(1'b0, 8'h10, 8'h00);
    chk(q, 8'h00);
    wb(1'b1, bpe_pkg::IDX_STATUS, 8'hff);
    wb(1'b0, bpe_pkg::IDX_STATUS, 8'h00);
    chk(q, 8'h00);
    for (int j = 0; j < 2; j++) begin
      cfg(bpe_pkg::PS_REP, j[0], j[0] ? 4'hf : 4'h0, 3'h0, PAT);
      mode <= 2'h1;
      grab(96);
      e = '0;
      for (int i = 0; i < 96; i++) e[i] = PAT[i % (j[0] ? 32 : 17)] ^ j[0];
      chk(v, e);
      chk(synced, 1'b1);
    end
    wb(1'b0, bpe_pkg::IDX_STATUS, 8'h00);
    wb(1'b1, bpe_pkg::IDX_MASK, 8'h40);
    for (int j = 0; j < 2; j++) begin
      wb(1'b1, bpe_pkg::IDX_CTRL2, 8'h1f);
      grab(40);
      chk(irq, !j[0]);
      wb(1'b0, bpe_pkg::IDX_STATUS, 8'h00);
      chk(q & 8'h41, 8'h41);
      chk(irq, 1'b0);
      wb(1'b1, bpe_pkg::IDX_CTRL2, 8'h0f);
      wb(1'b1, bpe_pkg::IDX_MASK, 8'h00);
    end
    for (int j = 1; j < 3; j++) begin
      cfg(bpe_pkg::PS_REP, 1'b0, 4'hf, 3'(j), PAT);
      mode <= 2'h1;
      grab(j * 100);
      e = '0;
      for (int i = 0; i < j * 100; i++) e[i] = PAT[i % 32];
      chk($countones(v ^ e), j == 1 ? 10 : 2);
    end
    cfg(bpe_pkg::PS_REP, 1'b0, 4'hf, 3'h0, PAT);
    mode <= 2'h1;
    grab(96);
    wb(1'b0, bpe_pkg::IDX_STATUS, 8'h00);
    wb(1'b1, bpe_pkg::IDX_MASK, 8'h01);
    mode <= 2'h0;
    wb(1'b1, bpe_pkg::IDX_CTRL1, {3'h4, bpe_pkg::PS_REP, 2'b01});
    repeat (2) @(posedge clk);
    chk(synced, 1'b0);
    chk(irq, 1'b1);
    wb(1'b0, bpe_pkg::IDX_STATUS, 8'h00);
    chk(q & 8'h02, 8'h02);
    chk(irq, 1'b0);
    wb(1'b1, bpe_pkg::IDX_CTRL1, {3'h4, bpe_pkg::PS_REP, 2'b11});
    wb(1'b0, bpe_pkg::IDX_BCNT0, 8'h00);
    chk(q, 8'h00);
    mode <= 2'h1;
    grab(96);
    chk(synced & irq, 1'b1);
    wb(1'b0, bpe_pkg::IDX_BCNT0, 8'h00);
    chk(q != 8'h00, 1'b1);
    for (int j = 2; j < 4; j++) begin
      mode <= 2'(j);
      grab(40);
      wb(1'b0, bpe_pkg::IDX_STATUS, 8'h00);
      chk(q & 8'h0c, j == 2 ? 8'h04 : 8'h0c);
      wb(1'b0, bpe_pkg::IDX_STATUS, 8'h00);
      chk(q & 8'h0c, j == 2 ? 8'h04 : 8'h08);
      chk(q & 8'h30, 8'h00);
    end
    gap <= 2'h2;
    wb(1'b1, bpe_pkg::IDX_AWC, 8'h02);
    cfg(bpe_pkg::PS_ALT, 1'b0, 4'h0, 3'h0, 32'hffff0000);
    mode <= 2'h1;
    grab(128);
    e = '0;
    for (int i = 0; i < 128; i++) e[i] = i[5];
    chk(v, e);
    // Odd passes invert both ways; a pseudorandom stream only locks if receive undoes it
    for (int j = 0; j < 5; j++) begin
      cfg(prbs[j], j[0], 4'h5, 3'h0, 32'hffffffff);
      mode <= 2'h1;
      grab(128);
      chk(synced, 1'b1);
    end
    summarize();
  end
endmodule
